// ### sync_slave_serial_transmit.sv
// What this block does
// - Sync-select bit 1 gives synchronous operation, 0 gives asynchronous.
// - Clock-source select 0 makes the synchronous port a slave of the clock pin.
// - Both receive enables 0 means transmit; either 1 means receive.
// - Serial port works only while the port enable bit is 1.
// - Slave transmit equals master transmit except for sleep behaviour.
// - First buffered word moves at once to the shift register and shifts.
// - Second word waits in the buffer; buffer-empty flag stays clear meanwhile.
// - After first word leaves, second loads, then buffer-empty flag sets.
// - Flag with both enables wakes from sleep; global enable also vectors.
// - Nine-bit select sends nine bits, ninth from the ninth-data bit.
// - Transmit only while enabled; writing the low byte starts it.
// - Ninth bit is sampled when the buffer write happens.
// - Clock pin is digital only while its analog select is clear.
//
// The strobed register port and the register addresses were chosen for this implementation.
module sync_slave_serial_transmit (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [sst_pkg::ADDR_W-1:0] addr_in,
    input wire logic [sst_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [sst_pkg::DATA_W-1:0] rdata_out,
    input wire logic serial_clock_pin_in,
    input wire logic sleep_in,
    output logic data_pin_out,
    output logic data_pin_oe_n_out,
    output logic irq_out,
    output logic wake_out,
    output logic vector_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [sst_pkg::TXC_W-1:0] tx_ctrl_q;
    logic [sst_pkg::RXC_W-1:0] rx_ctrl_q;
    logic [sst_pkg::INT_W-1:0] int_ctrl_q;
    logic [sst_pkg::EVT_W-1:0] status_q;
    logic [sst_pkg::EVT_W-1:0] status_d;
    logic [sst_pkg::EVT_W-1:0] mask_q;
    logic [sst_pkg::WORD_W-1:0] buf_q;
    logic buf_full_q;
    logic tx_empty_q;
    logic ck_s1_q;
    logic ck_s2_q;
    logic ck_s3_q;
    logic [sst_pkg::DATA_W-1:0] rdata_q;
    logic data_q;
    logic oe_n_q;
    logic irq_q;
    logic wake_q;
    logic vector_q;

    shift_if sh_if ();

    shift_out_reg u_shift (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .sh_if(sh_if.shifter)
    );

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire sync_mode = tx_ctrl_q[sst_pkg::TXC_SYNC];
    wire slave_mode = sync_mode && !tx_ctrl_q[sst_pkg::TXC_CLK_SRC];
    wire tx_mode = !rx_ctrl_q[sst_pkg::RXC_SINGLE] && !rx_ctrl_q[sst_pkg::RXC_CONT];
    wire port_on = rx_ctrl_q[sst_pkg::RXC_SERIAL_PORT_ENABLE];
    wire slave_tx = slave_mode && tx_mode && port_on;
    // Same path whether awake or asleep; sleep only changes what the flag does
    wire tx_active = slave_tx && tx_ctrl_q[sst_pkg::TXC_TX_EN];

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire wr_tx_ctrl = wr_in && (addr_in == sst_pkg::OFF_TX_CTRL);
    wire wr_rx_ctrl = wr_in && (addr_in == sst_pkg::OFF_RX_CTRL);
    wire wr_tx_buf = wr_in && (addr_in == sst_pkg::OFF_TX_BUF);
    wire wr_status = wr_in && (addr_in == sst_pkg::OFF_STATUS);
    wire wr_mask = wr_in && (addr_in == sst_pkg::OFF_MASK);
    wire wr_int_ctrl = wr_in && (addr_in == sst_pkg::OFF_INT_CTRL);
    // A write while the buffer is still full is dropped, not overwritten
    wire buf_take = wr_tx_buf && tx_active && !buf_full_q;
    wire [sst_pkg::WORD_W-1:0] buf_word = {tx_ctrl_q[sst_pkg::TXC_NINTH], wdata_in};

    // ------------------------------------------------------------
    // Serial clock pin
    // ------------------------------------------------------------
    // Analog select forces the digital path low so no stray edges appear
    wire ck_digital = serial_clock_pin_in && !tx_ctrl_q[sst_pkg::TXC_ANALOG];
    wire ck_fall = ck_s3_q && !ck_s2_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
        end else begin
            ck_s1_q <= ck_digital;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Buffer to shift register hand-off
    // ------------------------------------------------------------
    wire load_now = buf_full_q && !sh_if.busy && tx_active;
    wire tx_empty_d = !buf_full_q || load_now;

    assign sh_if.load = load_now;
    assign sh_if.word = buf_q;
    assign sh_if.nine = tx_ctrl_q[sst_pkg::TXC_NINE];
    assign sh_if.abort = !tx_active;
    assign sh_if.shift_edge = ck_fall;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !tx_active) begin
            buf_q <= 9'h000;
            buf_full_q <= 1'b0;
        end else if (buf_take) begin
            buf_q <= buf_word;
            buf_full_q <= 1'b1;
        end else if (load_now) begin
            buf_full_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            tx_empty_q <= 1'b1;
        end else begin
            tx_empty_q <= tx_empty_d;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            tx_ctrl_q <= sst_pkg::TX_CTRL_RST;
            rx_ctrl_q <= sst_pkg::RX_CTRL_RST;
            int_ctrl_q <= sst_pkg::INT_CTRL_RST;
            mask_q <= sst_pkg::EVT_RST;
        end else begin
            if (wr_tx_ctrl) begin
                tx_ctrl_q <= wdata_in[sst_pkg::TXC_W-1:0];
            end
            if (wr_rx_ctrl) begin
                rx_ctrl_q <= wdata_in[sst_pkg::RXC_W-1:0];
            end
            if (wr_int_ctrl) begin
                int_ctrl_q <= wdata_in[sst_pkg::INT_W-1:0];
            end
            if (wr_mask) begin
                mask_q <= wdata_in[sst_pkg::EVT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Events and interrupts
    // ------------------------------------------------------------
    wire [sst_pkg::EVT_W-1:0] evt;
    assign evt[sst_pkg::EVT_TX_EMPTY] = tx_empty_d && !tx_empty_q;
    assign evt[sst_pkg::EVT_WORD_DONE] = sh_if.done;
    // Set beats clear so an event in the clearing cycle survives
    wire [sst_pkg::EVT_W-1:0] clr = wr_status ? wdata_in[sst_pkg::EVT_W-1:0] : sst_pkg::EVT_RST;

    always_comb begin
        status_d = (status_q & ~clr) | evt;
    end

    wire int_armed = tx_empty_q && int_ctrl_q[sst_pkg::INT_TRANSMIT_INTERRUPT_ENABLE]
                     && int_ctrl_q[sst_pkg::INT_PERIPHERAL_INTERRUPT_ENABLE];
    wire wake_d = int_armed && sleep_in;
    wire vector_d = int_armed && int_ctrl_q[sst_pkg::INT_GIE];
    wire irq_d = |(status_q & mask_q);

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            status_q <= sst_pkg::EVT_RST;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
            vector_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= irq_d;
            wake_q <= wake_d;
            vector_q <= vector_d;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    wire [sst_pkg::FLG_W-1:0] flags;
    assign flags[sst_pkg::FLG_TX_EMPTY] = tx_empty_q;
    assign flags[sst_pkg::FLG_BUSY] = sh_if.busy;
    assign flags[sst_pkg::FLG_MODE] = slave_tx;

    wire [sst_pkg::DATA_W-1:0] rd_mux =
        (addr_in == sst_pkg::OFF_TX_CTRL) ? {2'h0, tx_ctrl_q} :
        (addr_in == sst_pkg::OFF_RX_CTRL) ? {5'h00, rx_ctrl_q} :
        (addr_in == sst_pkg::OFF_TX_BUF) ? buf_q[sst_pkg::DATA_W-1:0] :
        (addr_in == sst_pkg::OFF_STATUS) ? {6'h00, status_q} :
        (addr_in == sst_pkg::OFF_MASK) ? {6'h00, mask_q} :
        (addr_in == sst_pkg::OFF_INT_CTRL) ? {5'h00, int_ctrl_q} :
        (addr_in == sst_pkg::OFF_FLAGS) ? {5'h00, flags} : 8'h00;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_in ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    // Line is released whenever the slave is not the transmitter
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            data_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            // Gate on the mode too: the abort lands one edge late in the shifter
            data_q <= (sh_if.busy && tx_active) ? sh_if.bit_out : 1'b0;
            oe_n_q <= !tx_active;
        end
    end

    assign rdata_out = rdata_q;
    assign data_pin_out = data_q;
    assign data_pin_oe_n_out = oe_n_q;
    assign irq_out = irq_q;
    assign wake_out = wake_q;
    assign vector_out = vector_q;

endmodule : sync_slave_serial_transmit

// ### sst_pkg.sv
package sst_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] OFF_TX_CTRL = 3'h0;
    localparam logic [2:0] OFF_RX_CTRL = 3'h1;
    localparam logic [2:0] OFF_TX_BUF = 3'h2;
    localparam logic [2:0] OFF_STATUS = 3'h3;
    localparam logic [2:0] OFF_MASK = 3'h4;
    localparam logic [2:0] OFF_INT_CTRL = 3'h5;
    localparam logic [2:0] OFF_FLAGS = 3'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TXC_SYNC = 0;
    localparam int TXC_CLK_SRC = 1;
    localparam int TXC_NINE = 2;
    localparam int TXC_TX_EN = 3;
    localparam int TXC_NINTH = 4;
    localparam int TXC_ANALOG = 5;
    localparam int TXC_W = 6;
    localparam int RXC_SERIAL_PORT_ENABLE = 0;
    localparam int RXC_SINGLE = 1;
    localparam int RXC_CONT = 2;
    localparam int RXC_W = 3;
    localparam int INT_TRANSMIT_INTERRUPT_ENABLE = 0;
    localparam int INT_PERIPHERAL_INTERRUPT_ENABLE = 1;
    localparam int INT_GIE = 2;
    localparam int INT_W = 3;
    localparam int EVT_TX_EMPTY = 0;
    localparam int EVT_WORD_DONE = 1;
    localparam int EVT_W = 2;
    localparam int FLG_TX_EMPTY = 0;
    localparam int FLG_BUSY = 1;
    localparam int FLG_MODE = 2;
    localparam int FLG_W = 3;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [TXC_W-1:0] TX_CTRL_RST = 6'h00;
    localparam logic [RXC_W-1:0] RX_CTRL_RST = 3'h0;
    localparam logic [INT_W-1:0] INT_CTRL_RST = 3'h0;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam int WORD_W = 9;
    localparam int REF_CLK_PERIOD_NS = 40;

endpackage : sst_pkg

// ### shift_if.sv
interface shift_if;
    logic load;
    logic [8:0] word;
    logic nine;
    logic abort;
    logic shift_edge;
    logic busy;
    logic bit_out;
    logic done;

    modport ctrl (output load, output word, output nine, output abort, output shift_edge,
                  input busy, input bit_out, input done);
    modport shifter (input load, input word, input nine, input abort, input shift_edge,
                     output busy, output bit_out, output done);
endinterface : shift_if

// ### shift_out_reg.sv
module shift_out_reg (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    shift_if.shifter sh_if
);

    typedef enum logic [1:0] {
        SH_IDLE = 2'b01,
        SH_SHIFT = 2'b10
    } shift_state_e;

    shift_state_e state_q;
    logic [sst_pkg::WORD_W-1:0] data_q;
    logic [3:0] cnt_q;
    logic done_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in || sh_if.abort) begin
            state_q <= SH_IDLE;
            data_q <= 9'h000;
            cnt_q <= 4'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                SH_IDLE: begin
                    if (sh_if.load) begin
                        data_q <= sh_if.word;
                        cnt_q <= sh_if.nine ? sst_pkg::BITS_NINE : sst_pkg::BITS_EIGHT;
                        state_q <= SH_SHIFT;
                    end
                end
                SH_SHIFT: begin
                    // Each master clock fall moves on one bit; the pin never clocks itself
                    if (sh_if.shift_edge) begin
                        if (cnt_q == 4'h1) begin
                            state_q <= SH_IDLE;
                            done_q <= 1'b1;
                        end else begin
                            data_q <= {1'b0, data_q[sst_pkg::WORD_W-1:1]};
                            cnt_q <= cnt_q - 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= SH_IDLE;
                end
            endcase
        end
    end

    assign sh_if.bit_out = data_q[0];
    assign sh_if.busy = (state_q == SH_SHIFT);
    assign sh_if.done = done_q;

endmodule : shift_out_reg

// ### sst_checker_asserts.sv
module sst_checker (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [sst_pkg::ADDR_W-1:0] addr_in,
    input wire logic [sst_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [sst_pkg::DATA_W-1:0] rdata_out,
    input wire logic serial_clock_pin_in,
    input wire logic sleep_in,
    input wire logic data_pin_out,
    input wire logic data_pin_oe_n_out,
    input wire logic irq_out,
    input wire logic wake_out,
    input wire logic vector_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    // Cycles since a clock-pin fall or a bus write; pin may move only soon after one
    logic clk_pin_q;
    logic [3:0] evt_age_q;
    logic [3:0] evt_age_d;
    assign evt_age_d = ((clk_pin_q && !serial_clock_pin_in) || wr_in) ? 4'h0 :
        (evt_age_q == 4'hf) ? evt_age_q : evt_age_q + 4'h1;
    always_ff @(posedge ref_clk_in) begin
        clk_pin_q <= serial_clock_pin_in;
        evt_age_q <= srst_in ? 4'hf : evt_age_d;
    end
    a_idle_pin_low: assert property (data_pin_oe_n_out |-> !data_pin_out)
        else $error("data pin high while not driven");
    a_pin_moves_on_event: assert property (
        !data_pin_oe_n_out && !$past(data_pin_oe_n_out) && $changed(data_pin_out)
        |-> evt_age_q <= 4'h8)
        else $error("data pin moved without a clock fall");
    a_pin_hold_still: assert property (
        (!wr_in && $stable(serial_clock_pin_in))[*8] |-> $stable(data_pin_out))
        else $error("data pin moved while clock pin idle");
    a_wake_needs_sleep: assert property (wake_out |-> $past(sleep_in))
        else $error("wake while awake");
    a_vector_with_wake: assert property (vector_out && $past(sleep_in) |-> wake_out)
        else $error("vector without wake in sleep");
    a_gie_off_vector: assert property (
        wr_in && addr_in == sst_pkg::OFF_INT_CTRL && !wdata_in[sst_pkg::INT_GIE]
        |=> ##1 !vector_out)
        else $error("vector after global enable cleared");
    a_transmit_interrupt_enable_off_wake: assert property (
        wr_in && addr_in == sst_pkg::OFF_INT_CTRL && !wdata_in[sst_pkg::INT_TRANSMIT_INTERRUPT_ENABLE]
        |=> ##1 !wake_out && !vector_out)
        else $error("wake after transmit enable cleared");
    a_reset_release: assert property ($fell(srst_in) |-> data_pin_oe_n_out
        && !irq_out && !wake_out && rdata_out == 8'h00)
        else $error("outputs not idle after reset");
endmodule : sst_checker

bind sync_slave_serial_transmit sst_checker u_sst_checker (.ref_clk_in(ref_clk_in),
    .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .serial_clock_pin_in(serial_clock_pin_in),
    .sleep_in(sleep_in), .data_pin_out(data_pin_out),
    .data_pin_oe_n_out(data_pin_oe_n_out), .irq_out(irq_out),
    .wake_out(wake_out), .vector_out(vector_out));

// ### sst_master_model.sv
module sst_master_model (
    output logic sclk_out,
    input wire logic data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got;
    // Clock idles low between frames
    initial sclk_out = 1'b0;
    task automatic frame(input int n);
        got = 9'h000;
        #7;
        for (int i = 0; i < n; i++) begin
            #160 sclk_out = 1'b1;
            // Sample late in the bit, just before the shifting fall
            #150 got[i] = data_in;
            #10 sclk_out = 1'b0;
        end
    endtask : frame
endmodule : sst_master_model

// ### tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [5:0] tx; logic [7:0] d; logic [8:0] e;} row_s;
    logic ref_clk_in;
    logic srst_in = 1'b1;
    logic [sst_pkg::ADDR_W-1:0] addr_in = '0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sleep_in = 1'b0;
    logic [7:0] rdata_out;
    logic sclk;
    logic data_pin_out;
    logic oe_n;
    logic irq_out;
    logic wake_out;
    logic vector_out;
    logic [7:0] rv;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    row_s rows [4] = '{'{6'h09, 8'ha5, 9'h0a5}, '{6'h0d, 8'hff, 9'h0ff},
                       '{6'h1d, 8'h3c, 9'h13c}, '{6'h19, 8'h81, 9'h081}};
    logic [5:0] bad_tx [6] = '{6'h08, 6'h0b, 6'h09, 6'h09, 6'h09, 6'h01};
    logic [2:0] bad_rx [6] = '{3'h1, 3'h1, 3'h0, 3'h3, 3'h5, 3'h1};

    sync_slave_serial_transmit dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .serial_clock_pin_in(sclk), .sleep_in(sleep_in),
        .data_pin_out(data_pin_out), .data_pin_oe_n_out(oe_n), .irq_out(irq_out),
        .wake_out(wake_out), .vector_out(vector_out));
    sst_master_model u_master (.sclk_out(sclk), .data_in(data_pin_out));

    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : idle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        d = rdata_out;
        @(posedge ref_clk_in);
    endtask : rd
    // Frame ends off-edge; realign before the next bus access
    task automatic xfer(input int n);
        u_master.frame(n);
        idle(8);
    endtask : xfer
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (12) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        @(posedge ref_clk_in);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), rv);
            chk(rv, (a == 6) ? 9'h001 : 9'h000);
        end
        chk(oe_n, 1'b1);
        // --------------------------------------------------------
        // Each broken mode bit: no transmit, buffer write dropped
        // --------------------------------------------------------
        foreach (bad_tx[i]) begin
            wr(sst_pkg::OFF_TX_CTRL, {2'h0, bad_tx[i]});
            wr(sst_pkg::OFF_RX_CTRL, {5'h00, bad_rx[i]});
            wr(sst_pkg::OFF_TX_BUF, 8'h5a);
            idle(3);
            rd(sst_pkg::OFF_FLAGS, rv);
            chk(rv, (i == 5) ? 9'h005 : 9'h001);
            chk(oe_n, 1'b1);
        end
        wr(sst_pkg::OFF_RX_CTRL, 8'h01);
        foreach (rows[i]) begin
            wr(sst_pkg::OFF_TX_CTRL, {2'h0, rows[i].tx});
            wr(sst_pkg::OFF_TX_BUF, rows[i].d);
            // Ninth bit flipped after the write must not reach the wire
            wr(sst_pkg::OFF_TX_CTRL, {2'h0, rows[i].tx ^ 6'h10});
            idle(4);
            xfer(rows[i].tx[2] ? 9 : 8);
            chk(u_master.got, rows[i].e);
            rd(sst_pkg::OFF_FLAGS, rv);
            chk(rv, 9'h005);
        end
        wr(sst_pkg::OFF_TX_CTRL, 8'h29);
        wr(sst_pkg::OFF_TX_BUF, 8'h96);
        idle(4);
        xfer(8);
        rd(sst_pkg::OFF_FLAGS, rv);
        chk(rv, 9'h007);
        wr(sst_pkg::OFF_TX_CTRL, 8'h09);
        idle(4);
        xfer(8);
        chk(u_master.got, 9'h096);
        // --------------------------------------------------------
        // Two words then sleep
        // --------------------------------------------------------
        wr(sst_pkg::OFF_INT_CTRL, 8'h07);
        wr(sst_pkg::OFF_MASK, 8'h01);
        wr(sst_pkg::OFF_TX_BUF, 8'hc3);
        idle(3);
        wr(sst_pkg::OFF_TX_BUF, 8'h5e);
        wr(sst_pkg::OFF_STATUS, 8'h03);
        sleep_in <= 1'b1;
        idle(3);
        rd(sst_pkg::OFF_FLAGS, rv);
        chk(rv, 9'h006);
        chk({irq_out, wake_out, vector_out}, 9'h000);
        xfer(8);
        chk(u_master.got, 9'h0c3);
        rd(sst_pkg::OFF_FLAGS, rv);
        chk(rv, 9'h007);
        chk({irq_out, wake_out, vector_out}, 9'h007);
        wr(sst_pkg::OFF_INT_CTRL, 8'h03);
        idle(3);
        chk({wake_out, vector_out}, 9'h002);
        xfer(8);
        chk(u_master.got, 9'h05e);
        wr(sst_pkg::OFF_MASK, 8'h00);
        idle(3);
        chk(irq_out, 1'b0);
        wr(sst_pkg::OFF_STATUS, 8'h03);
        wr(sst_pkg::OFF_MASK, 8'h01);
        rd(sst_pkg::OFF_STATUS, rv);
        chk({rv, irq_out}, 9'h000);
        sleep_in <= 1'b0;
        idle(3);
        chk(wake_out, 1'b0);
        wr(sst_pkg::OFF_INT_CTRL, 8'h00);
        idle(3);
        wrap_up();
    end
endmodule : tb
